// File: rtl/tec_timer.sv
// Timer / external event counter with match, capture and interrupt logic.
// Assumes one clock, a single-cycle register port, asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tec_timer #(
	parameter bit WIDE = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [tec_pkg::ADDR_W-1:0] addr_i,
	input wire logic [tec_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [tec_pkg::DATA_W-1:0] rdata_o,
	input wire logic [tec_pkg::CAP_MAX*tec_pkg::CAP_PINS-1:0] cap_pin_i,
	output logic [tec_pkg::NMATCH-1:0] mat_o,
	output logic [tec_pkg::NAUX-1:0] aux_mat_o,
	output logic irq_o
);
	import tec_pkg::*;

	// Variant geometry
	localparam int unsigned CW = WIDE ? TC_W_WIDE : TC_W_NARROW;
	localparam int unsigned NCAP = WIDE ? NCAP_WIDE : NCAP_NARROW;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [CTRL_W-1:0] ctrl_reg;
	logic [CW-1:0] pr_reg;
	logic [CW-1:0] pc_reg;
	logic [CW-1:0] tc_reg;
	logic [CW-1:0] match_reg [NMATCH];
	logic [CW-1:0] cap_reg [CAP_MAX];
	logic [NMATCH*MCTL_FW-1:0] mctl_reg;
	logic [CAP_MAX*CCTL_FW-1:0] cctl_reg;
	logic [CAP_MAX*CPIN_FW-1:0] cpin_reg;
	logic [NMATCH*ACT_W-1:0] act_reg;
	logic [NAUX*SEL_W-1:0] bcast_reg;
	logic [STAT_W-1:0] stat_reg;
	logic [STAT_W-1:0] stat_next;
	logic [STAT_W-1:0] mask_reg;
	logic [CAP_MAX-1:0] chan_prev_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic irq_reg;
	logic [NAUX-1:0] aux_reg;

	logic [CAP_MAX*CAP_PINS-1:0] pin_lvl;
	logic [CAP_MAX-1:0] chan_lvl;
	logic [CAP_MAX-1:0] chan_rise;
	logic [CAP_MAX-1:0] chan_fall;
	logic [CAP_MAX-1:0] cap_ev;
	logic [NMATCH-1:0] hit;
	logic [NMATCH-1:0] m_int;
	logic [NMATCH-1:0] m_rst;
	logic [NMATCH-1:0] m_stop;
	logic [SEL_W-1:0] csel;
	logic run;
	logic tick;
	logic term;
	logic adv;
	logic any_rst;
	logic any_stop;
	logic wr_match;
	logic wr_stat;
	logic wr_emr;

	tec_match_if mif ();

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and match outputs
	tec_pin_sync #(
		.N(CAP_MAX * CAP_PINS)
	) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.pin_i(cap_pin_i),
		.level_o(pin_lvl)
	);

	tec_match_out u_mout (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.mif(mif)
	);

	assign wr_emr = wr_i && (addr_i == OFF_EMR);
	assign mif.hit = hit;
	assign mif.act = act_reg;
	assign mif.sw_wr = wr_emr;
	assign mif.sw_val = wdata_i[NMATCH-1:0];
	assign mat_o = mif.state;

	////////////////////////////////////////////////////////////////////////
	// Capture channels: pin combining and edge detection
	genvar c;
	for (c = 0; c < CAP_MAX; c++) begin : g_chan
		logic [CAP_PINS-1:0] en;
		logic [CAP_PINS-1:0] lv;
		logic [CCTL_FW-1:0] cc;
		assign en = cpin_reg[c*CPIN_FW +: CAP_PINS];
		assign lv = pin_lvl[c*CAP_PINS +: CAP_PINS];
		assign cc = cctl_reg[c*CCTL_FW +: CCTL_FW];
		// Enabled pins combine by AND or by OR
		assign chan_lvl[c] = cpin_reg[c*CPIN_FW + CPIN_AND] ?
			&(lv | ~en) : |(lv & en);
		assign chan_rise[c] = chan_lvl[c] & ~chan_prev_reg[c];
		assign chan_fall[c] = ~chan_lvl[c] & chan_prev_reg[c];
		// Channels beyond the variant's count never fire
		assign cap_ev[c] = ce_i && (c < NCAP) &&
			((cc[CCTL_RISE] && chan_rise[c]) ||
			(cc[CCTL_FALL] && chan_fall[c]));
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cap_reg[c] <= '0;
			end else if (cap_ev[c]) begin
				cap_reg[c] <= tc_reg;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			chan_prev_reg <= '0;
		end else if (ce_i) begin
			chan_prev_reg <= chan_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Count source, prescaler and match detection
	assign csel = ctrl_reg[CTRL_CSEL_LSB +: SEL_W];
	assign run = ctrl_reg[CTRL_EN] && !ctrl_reg[CTRL_CRST];
	assign tick = !ctrl_reg[CTRL_MODE] ||
		(ctrl_reg[CTRL_EDGE_LSB] && chan_rise[csel]) ||
		(ctrl_reg[CTRL_EDGE_LSB + 1] && chan_fall[csel]);
	assign term = (pc_reg == pr_reg);
	assign adv = ce_i && run && tick;

	genvar k;
	for (k = 0; k < NMATCH; k++) begin : g_match
		assign m_int[k] = mctl_reg[k*MCTL_FW + MCTL_INT];
		assign m_rst[k] = mctl_reg[k*MCTL_FW + MCTL_RST];
		assign m_stop[k] = mctl_reg[k*MCTL_FW + MCTL_STOP];
		assign hit[k] = adv && term && (tc_reg == match_reg[k]);
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				match_reg[k] <= '0;
			end else if (ce_i && wr_match && (addr_i[IDX_LSB +: SEL_W] == k)) begin
				match_reg[k] <= wdata_i[CW-1:0];
			end
		end
	end

	assign any_rst = |(hit & m_rst);
	assign any_stop = |(hit & m_stop);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_reg <= '0;
			tc_reg <= '0;
		end else if (ce_i) begin
			if (ctrl_reg[CTRL_CRST] || (adv && term && any_rst)) begin
				pc_reg <= '0;
				tc_reg <= '0;
			end else if (adv && term && any_stop) begin
				pc_reg <= '0;
			end else if (adv && term) begin
				pc_reg <= '0;
				tc_reg <= tc_reg + 1'b1;
			end else if (adv) begin
				pc_reg <= pc_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes
	assign wr_match = wr_i && (addr_i[ADDR_W-1:BLK_LSB] ==
		OFF_MATCH[ADDR_W-1:BLK_LSB]);
	assign wr_stat = ce_i && wr_i && (addr_i == OFF_STAT);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_reg <= CTRL_RST;
		end else if (ce_i) begin
			if (wr_i && (addr_i == OFF_CTRL)) begin
				ctrl_reg <= wdata_i[CTRL_W-1:0];
			end
			// A stopping match wins over a software write
			if (any_stop) begin
				ctrl_reg[CTRL_EN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pr_reg <= '0;
			mctl_reg <= '0;
			cctl_reg <= '0;
			cpin_reg <= {CAP_MAX{CPIN_RST}};
			act_reg <= '0;
			bcast_reg <= '0;
			mask_reg <= '0;
		end else if (ce_i && wr_i) begin
			case (addr_i)
				OFF_PR: pr_reg <= wdata_i[CW-1:0];
				OFF_MCTL: mctl_reg <= wdata_i[NMATCH*MCTL_FW-1:0];
				OFF_CCTL: cctl_reg <= wdata_i[CAP_MAX*CCTL_FW-1:0];
				OFF_CPIN: cpin_reg <= wdata_i[CAP_MAX*CPIN_FW-1:0];
				OFF_EMR: act_reg <= wdata_i[EMR_ACT_LSB +: NMATCH*ACT_W];
				OFF_BCAST: bcast_reg <= wdata_i[NAUX*SEL_W-1:0];
				OFF_MASK: mask_reg <= wdata_i[STAT_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt flags: set wins over write-one clear
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_next & ~wdata_i[STAT_W-1:0];
		end
		stat_next[NMATCH-1:0] = stat_next[NMATCH-1:0] | (hit & m_int);
		for (int i = 0; i < CAP_MAX; i++) begin
			if (cap_ev[i] && cctl_reg[i*CCTL_FW + CCTL_INT]) begin
				stat_next[STAT_CAP_LSB + i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stat_reg <= '0;
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			stat_reg <= stat_next;
			irq_reg <= |(stat_reg & mask_reg);
		end
	end

	assign irq_o = irq_reg;

	// Broadcast pins copy a chosen match output
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aux_reg <= '0;
		end else if (ce_i) begin
			for (int j = 0; j < NAUX; j++) begin
				aux_reg[j] <= mif.state[bcast_reg[j*SEL_W +: SEL_W]];
			end
		end
	end

	assign aux_mat_o = aux_reg;

	////////////////////////////////////////////////////////////////////////
	// Register reads: data stand only in the cycle after the strobe
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			if (addr_i[ADDR_W-1:BLK_LSB] == OFF_MATCH[ADDR_W-1:BLK_LSB]) begin
				rdata_next = DATA_W'(match_reg[addr_i[IDX_LSB +: SEL_W]]);
			end else if (addr_i[ADDR_W-1:BLK_LSB] ==
				OFF_CAP[ADDR_W-1:BLK_LSB]) begin
				rdata_next = DATA_W'(cap_reg[addr_i[IDX_LSB +: SEL_W]]);
			end else begin
				case (addr_i)
					OFF_CTRL: rdata_next = DATA_W'(ctrl_reg);
					OFF_TC: rdata_next = DATA_W'(tc_reg);
					OFF_PR: rdata_next = DATA_W'(pr_reg);
					OFF_PC: rdata_next = DATA_W'(pc_reg);
					OFF_EMR: rdata_next = DATA_W'({act_reg, mif.state});
					OFF_MCTL: rdata_next = DATA_W'(mctl_reg);
					OFF_CCTL: rdata_next = DATA_W'(cctl_reg);
					OFF_CPIN: rdata_next = DATA_W'(cpin_reg);
					OFF_STAT: rdata_next = DATA_W'(stat_reg);
					OFF_MASK: rdata_next = DATA_W'(mask_reg);
					OFF_BCAST: rdata_next = DATA_W'(bcast_reg);
					default: rdata_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= '0;
		end else if (ce_i) begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_tc_advance: assert property (adv && term && !any_rst
		&& !any_stop |=> tc_reg == $past(tc_reg) + 1'b1 && pc_reg == '0)
		else $error("counter did not advance at prescaler end");
	a_presc_count: assert property (adv && !term
		|=> pc_reg == $past(pc_reg) + 1'b1 && $stable(tc_reg))
		else $error("prescaler did not count a tick");
	a_count_hold: assert property (ce_i && run
		&& ctrl_reg[CTRL_MODE] && !tick
		|=> $stable(tc_reg) && $stable(pc_reg))
		else $error("counter moved without an input event");
	a_match_reset: assert property (adv && term && any_rst
		|=> tc_reg == '0 && pc_reg == '0)
		else $error("reset on match did not clear counter");
	a_match_stop: assert property (any_stop
		|=> !ctrl_reg[CTRL_EN] ##1 $stable(tc_reg))
		else $error("stop on match did not halt counter");
	a_match_flag: assert property (hit[0] && m_int[0] |=> stat_reg[0])
		else $error("match flag not set");
	a_flag_sticky: assert property (stat_reg[0] && ce_i
		&& !(wr_stat && wdata_i[0]) |=> stat_reg[0])
		else $error("flag cleared without a write of one");
	a_irq_level: assert property (ce_i
		&& |(stat_reg & mask_reg) |=> irq_o)
		else $error("interrupt line low with enabled flag");
	a_capture_latch: assert property (cap_ev[0]
		|=> cap_reg[0] == $past(tc_reg))
		else $error("capture did not latch the counter");
	a_out_toggle: assert property (hit[1]
		&& act_reg[ACT_W +: ACT_W] == ACT_TOGGLE
		|=> mat_o[1] != $past(mat_o[1]))
		else $error("match output did not toggle");
	a_narrow_cap: assert property (NCAP == CAP_MAX
		|| !cap_ev[CAP_MAX-1])
		else $error("absent capture channel fired");

	c_match_reset: cover property (adv && term && any_rst);
	c_match_stop: cover property (any_stop);
	c_capture: cover property (cap_ev[1] ##1 stat_reg[STAT_CAP_LSB + 1]);
	c_event_count: cover property (ce_i && run && ctrl_reg[CTRL_MODE] && tick);

endmodule : tec_timer
`default_nettype wire

// File: rtl/tec_pkg.sv
// Constants, register map and types of the timer / event counter.
// Assumes a single peripheral clock; every user file imports this package.
package tec_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned TC_W_WIDE = 32;
	localparam int unsigned TC_W_NARROW = 16;
	localparam int unsigned NCAP_WIDE = 4;
	localparam int unsigned NCAP_NARROW = 3;
	localparam int unsigned CAP_MAX = 4;
	localparam int unsigned CAP_PINS = 2;
	localparam int unsigned NMATCH = 4;
	localparam int unsigned NAUX = 2;
	localparam int unsigned ACT_W = 2;
	localparam int unsigned SEL_W = 2;
	localparam int unsigned STAT_W = NMATCH + CAP_MAX;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PR = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PC = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_MATCH = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_EMR = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_MCTL = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_CCTL = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CPIN = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_CAP = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_BCAST = 8'h48;
	localparam int unsigned BLK_LSB = 4;
	localparam int unsigned IDX_LSB = 2;

	////////////////////////////////////////////////////////////////////////
	// Field layouts
	localparam int unsigned CTRL_W = 7;
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_CRST = 1;
	localparam int unsigned CTRL_MODE = 2;
	localparam int unsigned CTRL_EDGE_LSB = 3;
	localparam int unsigned CTRL_CSEL_LSB = 5;
	localparam int unsigned MCTL_INT = 0;
	localparam int unsigned MCTL_RST = 1;
	localparam int unsigned MCTL_STOP = 2;
	localparam int unsigned MCTL_FW = 3;
	localparam int unsigned CCTL_RISE = 0;
	localparam int unsigned CCTL_FALL = 1;
	localparam int unsigned CCTL_INT = 2;
	localparam int unsigned CCTL_FW = 3;
	localparam int unsigned CPIN_AND = 2;
	localparam int unsigned CPIN_FW = 3;
	localparam int unsigned EMR_ACT_LSB = NMATCH;
	localparam int unsigned STAT_CAP_LSB = NMATCH;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [CPIN_FW-1:0] CPIN_RST = 3'h1;

	typedef enum logic [ACT_W-1:0] {
		ACT_NONE,
		ACT_LOW,
		ACT_HIGH,
		ACT_TOGGLE
	} tec_act_e;

endpackage : tec_pkg

// File: rtl/tec_match_if.sv
// Carrier between the counter core and the match output stage.
// Assumes tec_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface tec_match_if;
	import tec_pkg::*;
	logic [NMATCH-1:0] hit;
	logic [NMATCH*ACT_W-1:0] act;
	logic sw_wr;
	logic [NMATCH-1:0] sw_val;
	logic [NMATCH-1:0] state;
	modport timer (output hit, output act, output sw_wr, output sw_val,
		input state);
	modport outs (input hit, input act, input sw_wr, input sw_val,
		output state);
endinterface : tec_match_if
`default_nettype wire

// File: rtl/tec_pin_sync.sv
// Three-stage synchroniser with agreement filter for external pins.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tec_pin_sync #(
	parameter int unsigned N = tec_pkg::CAP_MAX * tec_pkg::CAP_PINS
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [N-1:0] pin_i,
	output logic [N-1:0] level_o
);
	import tec_pkg::*;

	genvar g;
	for (g = 0; g < N; g++) begin : g_pin
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		logic lvl_reg;
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				s3_reg <= 1'b0;
				lvl_reg <= 1'b0;
			end else if (ce_i) begin
				s1_reg <= pin_i[g];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				// A change counts once stages two and three agree
				if (s2_reg == s3_reg) begin
					lvl_reg <= s3_reg;
				end
			end
		end
		assign level_o[g] = lvl_reg;
	end

endmodule : tec_pin_sync
`default_nettype wire

// File: rtl/tec_match_out.sv
// Match-driven external output stage, one flip-flop per output.
// Assumes hit pulses come from the counter core on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tec_match_out (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	tec_match_if.outs mif
);
	import tec_pkg::*;

	genvar k;
	for (k = 0; k < NMATCH; k++) begin : g_out
		logic st_reg;
		tec_act_e act;
		assign act = tec_act_e'(mif.act[k*ACT_W +: ACT_W]);
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				st_reg <= 1'b0;
			end else if (ce_i) begin
				// A match action wins over a software write
				if (mif.hit[k]) begin
					case (act)
						ACT_LOW: st_reg <= 1'b0;
						ACT_HIGH: st_reg <= 1'b1;
						ACT_TOGGLE: st_reg <= ~st_reg;
						default: st_reg <= st_reg;
					endcase
				end else if (mif.sw_wr) begin
					st_reg <= mif.sw_val[k];
				end
			end
		end
		assign mif.state[k] = st_reg;
	end

endmodule : tec_match_out
`default_nettype wire

// File: sim/tec_pin_model.sv
// Partner model: external sources on the capture and count pins.
// Assumes the bench asks for a pulse with a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module tec_pin_model #(
	parameter int unsigned N = 8
) (
	input wire logic clk_i,
	input wire logic [N-1:0] ev_i,
	input wire logic [3:0] hold_i,
	output logic [N-1:0] pins_o
);
	logic [3:0] cnt_reg;

	initial begin
		pins_o = '0;
		cnt_reg = 4'h0;
	end

	// Pulse never shorter than one clock period
	always @(posedge clk_i) begin
		if (ev_i != '0) begin
			pins_o <= ev_i;
			cnt_reg <= (hold_i == 4'h0) ? 4'h1 : hold_i;
		end else if (cnt_reg > 4'h1) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else begin
			cnt_reg <= 4'h0;
			pins_o <= '0;
		end
	end
endmodule : tec_pin_model
`default_nettype wire

// File: sim/tec_timer_tb.sv
// Self-checking bench of the timer / event counter, wide variant.
// Assumes tec_pkg, the design files and tec_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tec_timer_tb;
	import tec_pkg::*;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, s); end end

	logic clk_i, reset_n_i, wr_i, rd_i, irq_o, ce;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o;
	logic [7:0] cap_pin_i, ev;
	logic [3:0] hold;
	logic [NMATCH-1:0] mat_o;
	logic [NAUX-1:0] aux_mat_o;
	int n_fail, checks, seed, i, k;
	logic [31:0] d, t0, t1, m, pr;

	tec_timer #(.WIDE(1'b1)) u_tec_timer (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .ce_i(ce), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.cap_pin_i(cap_pin_i), .mat_o(mat_o), .aux_mat_o(aux_mat_o),
		.irq_o(irq_o));
	tec_pin_model #(.N(8)) u_tec_pin_model (.clk_i(clk_i), .ev_i(ev),
		.hold_i(hold), .pins_o(cap_pin_i));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_fail == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask : bus_rd

	task automatic pulse(input logic [7:0] p);
		@(posedge clk_i);
		ev <= p;
		hold <= 4'h3;
		@(posedge clk_i);
		ev <= 8'h00;
		repeat (8) @(posedge clk_i);
	endtask : pulse

	task automatic wait_irq();
		for (int j = 0; j < 400; j++) begin
			@(posedge clk_i);
			#1;
			if (irq_o === 1'b1) return;
		end
		n_fail++;
		results();
	endtask : wait_irq

	// Poll until a stop-on-match has cleared the enable bit
	task automatic wait_stop();
		logic [31:0] v;
		for (int j = 0; j < 300; j++) begin
			bus_rd(OFF_CTRL, v);
			if (v[0] === 1'b0) return;
		end
		n_fail++;
		results();
	endtask : wait_stop

	function automatic logic [3:0] exp_mat(input int a);
		logic s;
		s = a[2];
		case (a[1:0])
			2'd0: return {4{s}};
			2'd1: return 4'h0;
			2'd2: return 4'hf;
			default: return {4{~s}};
		endcase
	endfunction : exp_mat

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 48;
		n_fail = 0;
		checks = 0;
		reset_n_i = 1'b0;
		{wr_i, rd_i, ev, hold} = '0;
		ce = 1'b1;
		addr_i = '0;
		wdata_i = '0;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		bus_rd(OFF_CPIN, d);
		`CHK("cpin", 32'h249, d)
		bus_rd(8'hfc, d);
		`CHK("unmapped", 32'h0, d)
		`CHK("irq", 1'b0, irq_o)
		// Stop on match through the prescaler, masked then unmasked
		m = 32'd5 + 32'($unsigned($random(seed)) % 20);
		pr = 32'($unsigned($random(seed)) % 4);
		bus_wr(OFF_PR, pr);
		bus_wr(OFF_MATCH + 8'h4, m);
		bus_wr(OFF_MCTL, 32'h28);
		bus_wr(OFF_CTRL, 32'h1);
		wait_stop();
		bus_rd(OFF_TC, d);
		`CHK("tc stop", m, d)
		bus_rd(OFF_PC, d);
		`CHK("pc stop", 32'h0, d)
		bus_rd(OFF_STAT, d);
		`CHK("stat", 32'h2, d)
		`CHK("irq", 1'b0, irq_o)
		bus_wr(OFF_MASK, 32'h2);
		repeat (2) @(posedge clk_i);
		#1;
		`CHK("irq", 1'b1, irq_o)
		bus_wr(OFF_STAT, 32'h2);
		repeat (2) @(posedge clk_i);
		#1;
		`CHK("irq", 1'b0, irq_o)
		// Reset on match with toggle; a second match only interrupts
		bus_wr(OFF_CTRL, 32'h2);
		bus_wr(OFF_MASK, 32'h1);
		bus_wr(OFF_MATCH, m);
		bus_wr(OFF_MATCH + 8'h8, m - 32'd2);
		bus_wr(OFF_MCTL, 32'h43);
		bus_wr(OFF_EMR, 32'h30);
		bus_wr(OFF_CTRL, 32'h1);
		wait_irq();
		`CHK("mat0", 1'b1, mat_o[0])
		bus_rd(OFF_TC, d);
		`CHK("tc reset", 32'd2 / (pr + 32'd1), d)
		for (k = 0; k < 6; k++) begin
			bus_rd(OFF_TC, d);
			`CHK("tc wrap", 1'b1, d <= m)
		end
		bus_rd(OFF_STAT, d);
		`CHK("stat", 32'h5, d)
		bus_wr(OFF_CTRL, 32'h0);
		bus_wr(OFF_STAT, 32'hff);
		bus_wr(OFF_MASK, 32'h0);
		// Every output action from both start levels, with broadcast
		bus_wr(OFF_PR, 32'h0);
		bus_wr(OFF_BCAST, 32'he);
		bus_wr(OFF_MCTL, 32'h924);
		for (i = 0; i < 4; i++) bus_wr(OFF_MATCH + 8'(i << 2), 32'h3);
		for (k = 0; k < 8; k++) begin
			bus_wr(OFF_CTRL, 32'h2);
			bus_wr(OFF_EMR, {20'h0, {4{k[1:0]}}, {4{k[2]}}});
			bus_wr(OFF_CTRL, 32'h1);
			wait_stop();
			d = 32'(exp_mat(k));
			`CHK("mat", d[3:0], mat_o)
			`CHK("aux", d[3:2], aux_mat_o)
		end
		// Capture on each channel while the timer runs
		bus_wr(OFF_MCTL, 32'h0);
		bus_wr(OFF_CCTL, 32'hb6d);
		bus_wr(OFF_MASK, 32'hf0);
		bus_wr(OFF_CTRL, 32'h1);
		for (k = 0; k < 4; k++) begin
			bus_rd(OFF_TC, t0);
			pulse(8'(1 << (2 * k)));
			wait_irq();
			bus_rd(OFF_CAP + 8'(k << 2), d);
			bus_rd(OFF_TC, t1);
			`CHK("cap", 1'b1, d > t0 && d < t1)
			bus_rd(OFF_STAT, d);
			`CHK("stat cap", 32'(1 << (4 + k)), d)
			bus_wr(OFF_STAT, 32'hff);
		end
		// Two pins in AND mode need both high
		bus_wr(OFF_CPIN, 32'h24f);
		pulse(8'h01);
		bus_rd(OFF_STAT, d);
		`CHK("and one", 32'h0, d)
		pulse(8'h03);
		bus_rd(OFF_STAT, d);
		`CHK("and both", 32'h10, d)
		// Event counting on channel 1, channel 0 still captures
		bus_wr(OFF_CPIN, 32'h249);
		bus_wr(OFF_STAT, 32'hff);
		bus_wr(OFF_CCTL, 32'h5);
		bus_wr(OFF_CTRL, 32'h2);
		bus_wr(OFF_CTRL, 32'h2d);
		m = 32'd1 + 32'($unsigned($random(seed)) % 6);
		for (k = 0; k < int'(m); k++) pulse(8'h04);
		pulse(8'h01);
		bus_rd(OFF_TC, d);
		`CHK("events", m, d)
		bus_rd(OFF_STAT, d);
		`CHK("stat ev", 32'h10, d)
		// Clock enable low freezes the running counter for 40 edges
		bus_wr(OFF_CTRL, 32'h1);
		bus_rd(OFF_TC, t0);
		@(posedge clk_i);
		ce <= 1'b0;
		repeat (40) @(posedge clk_i);
		ce <= 1'b1;
		bus_rd(OFF_TC, d);
		`CHK("tc freeze", t0 + 32'd3, d)
		results();
	end
endmodule : tec_timer_tb
`default_nettype wire
